/* File: rtl/analog_channel.v */
// One analog input channel: drift, offset, dead zone, low-pass, monitor
`timescale 1ns/1ns
`default_nettype none
`include "torque_path_defines.vh"

module analog_channel (
  // Clock and reset
  input  wire               sys_clk_i,
  input  wire               reset_i,
  // Timing
  input  wire               ms_tick_i,
  // Sample and calibration
  input  wire signed [15:0] raw_mv_i,
  input  wire               calibrate_i,
  // Settings
  input  wire signed [15:0] offset_mv_i,
  input  wire        [9:0]  dead_zone_mv_i,
  input  wire        [15:0] filter_tau_ms_i,
  // Results
  output reg  signed [15:0] filtered_mv_o,
  output reg  signed [15:0] monitor_mv_o,
  output reg  signed [15:0] zero_drift_o
);

  wire signed [31:0] raw_w;
  wire signed [31:0] corr_w;
  wire signed [31:0] offs_w;
  reg  signed [31:0] dz_w;
  reg  signed [31:0] acc_ff;
  reg  signed [31:0] nxt_acc;
  reg  signed [31:0] nxt_drift;
  wire signed [31:0] diff_w;

  assign raw_w  = raw_mv_i;
  assign corr_w = raw_w - zero_drift_o;
  assign offs_w = corr_w - offset_mv_i;

  always @* begin
    dz_w = offs_w;
    if (offs_w < $signed({22'h00_0000, dead_zone_mv_i}) &&
        offs_w > -$signed({22'h00_0000, dead_zone_mv_i})) begin
      dz_w = 32'h0000_0000;
    end
  end

  assign diff_w = (dz_w <<< `FILT_FRAC) - acc_ff;

  always @* begin
    nxt_acc = acc_ff;
    if (ms_tick_i) begin
      if (filter_tau_ms_i == 16'h0000) begin
        nxt_acc = dz_w <<< `FILT_FRAC;
      end else begin
        nxt_acc = acc_ff + diff_w / $signed({16'h0000, filter_tau_ms_i});
      end
    end
  end

  // Drift is the raw reading at zero input, clamped to its range
  always @* begin
    nxt_drift = raw_w;
    if (raw_w > $signed(`DRIFT_MAX)) begin
      nxt_drift = `DRIFT_MAX;
    end else if (raw_w < -$signed(`DRIFT_MAX)) begin
      nxt_drift = -$signed(`DRIFT_MAX);
    end
  end

  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      acc_ff        <= 32'h0000_0000;
      filtered_mv_o <= `TORQUE_RST;
      monitor_mv_o  <= `TORQUE_RST;
      zero_drift_o  <= `DRIFT_RST;
    end else begin
      acc_ff        <= nxt_acc;
      filtered_mv_o <= nxt_acc[`FILT_FRAC+15:`FILT_FRAC];
      monitor_mv_o  <= corr_w[15:0];
      if (calibrate_i) begin
        zero_drift_o <= nxt_drift[15:0];
      end
    end
  end

endmodule
`default_nettype wire

/* File: rtl/torque_path_defines.vh */
// Constants shared by the torque reference path
`ifndef TORQUE_PATH_DEFINES_VH
`define TORQUE_PATH_DEFINES_VH

// Clock rate and tick periods
`define CLK_MHZ        100
`define MS_TICK_NS     1000000
`define MS_TICK_CYC    (`MS_TICK_NS * `CLK_MHZ / 1000)
`define TAU_TICK_NS    10000
`define TAU_TICK_CYC   (`TAU_TICK_NS * `CLK_MHZ / 1000)

// Value limits
`define TORQUE_MAX     32'h0000_0BB8
`define DRIFT_MAX      32'h0000_01F4
`define FULL_SCALE_MV  32'h0000_2710
`define PCT_TO_TENTH   14'h000A

// Source selector codes
`define SRC_INTERNAL   1'b0
`define SRC_ANALOG     1'b1

// Output function codes
`define FUNC_LIMIT     8'h8A
`define FUNC_REACHED   8'h8B

// Reset values and filter fraction bits
`define DRIFT_RST      16'h0000
`define TORQUE_RST     16'h0000
`define TORQUE_LIM_RST 16'h0BB8
`define FILT_FRAC      8

`endif

/* File: rtl/torque_reference_path.v */
// Torque-mode reference selection, filtering, limiting and status outputs
// What this block does
// - Internal source uses stored signed setpoint, 0.1% steps, within +-300.0%.
// - Each analog channel subtracts a signed millivolt offset after drift removal.
// - Each analog channel reads zero inside a programmable dead-zone band.
// - Each channel holds a calibrated zero-drift value removed from every sample.
// - Each channel offers a monitor of input voltage in millivolts.
// - Analog torque scales linearly so 10 V equals the full-scale torque.
// - Torque command passes a first-order filter; tau may come from auto-tuning.
// - References beyond the active limit magnitude are replaced by the limit.
// - One limit source at a time; no limit exceeds 300.0%.
// - Limit source picks internal values or channel B, changed only when stopped.
// - Internal limits are separate forward and reverse values in 0.1% steps.
// - Limit flag, function code 138, drives an assigned output while limiting.
// - Torque-reached output compares feedback with threshold plus hysteresis.
// - Each output terminal has a function code and an active level.
// - Torque source picks internal setpoint or channel A, changed when stopped.
`timescale 1ns/1ns
`default_nettype none
`include "torque_path_defines.vh"

module torque_reference_path #(
  parameter MS_TICK_CYC = `MS_TICK_CYC
) (
  // Clock and reset
  input  wire               sys_clk_i,
  input  wire               reset_i,
  // Motor state
  input  wire               motor_stopped_i,
  input  wire               torque_mode_i,
  input  wire signed [15:0] speed_reg_torque_i,
  input  wire signed [15:0] torque_feedback_i,
  // Analog samples
  input  wire signed [15:0] analog_in_a_i,
  input  wire signed [15:0] analog_in_b_i,
  input  wire               calibrate_a_i,
  input  wire               calibrate_b_i,
  // Analog settings
  input  wire signed [15:0] offset_a_mv_i,
  input  wire signed [15:0] offset_b_mv_i,
  input  wire        [9:0]  dead_zone_a_mv_i,
  input  wire        [9:0]  dead_zone_b_mv_i,
  input  wire        [15:0] filter_tau_a_ms_i,
  input  wire        [15:0] filter_tau_b_ms_i,
  input  wire        [11:0] full_scale_torque_i,
  // Reference settings
  input  wire               torque_source_select_i,
  input  wire signed [15:0] internal_torque_setpoint_i,
  input  wire        [11:0] torque_filter_tau_i,
  input  wire               auto_tune_active_i,
  input  wire        [11:0] auto_filter_tau_i,
  // Limit settings
  input  wire               limit_source_select_i,
  input  wire        [11:0] forward_limit_value_i,
  input  wire        [11:0] reverse_limit_value_i,
  // Reached settings
  input  wire        [8:0]  torque_reached_level_i,
  input  wire        [4:0]  torque_reached_hyst_i,
  // Output terminals
  input  wire        [7:0]  do0_func_i,
  input  wire        [7:0]  do1_func_i,
  input  wire               do0_active_high_i,
  input  wire               do1_active_high_i,
  // Results
  output reg  signed [15:0] torque_cmd_o,
  output reg                torque_limit_flag_o,
  output reg                torque_reached_flag_o,
  output reg                do0_o,
  output reg                do1_o,
  output reg  signed [15:0] analog_a_monitor_o,
  output reg  signed [15:0] analog_b_monitor_o,
  output reg  signed [15:0] zero_drift_a_o,
  output reg  signed [15:0] zero_drift_b_o
);

  // Saturate to +-300.0%
  function [15:0] sat_torque;
    input signed [31:0] v;
    begin
      if (v > $signed(`TORQUE_MAX)) begin
        sat_torque = `TORQUE_LIM_RST;
      end else if (v < -$signed(`TORQUE_MAX)) begin
        sat_torque = -`TORQUE_LIM_RST;
      end else begin
        sat_torque = v[15:0];
      end
    end
  endfunction

  function [15:0] mag16;
    input signed [15:0] v;
    begin
      if (v < 0) begin
        mag16 = -v;
      end else begin
        mag16 = v;
      end
    end
  endfunction

  // Tick generation
  reg  [16:0] ms_cnt_ff;
  reg         ms_tick_ff;
  reg  [9:0]  tau_cnt_ff;
  reg         tau_tick_ff;

  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      ms_cnt_ff   <= 17'h0_0000;
      ms_tick_ff  <= 1'b0;
      tau_cnt_ff  <= 10'h000;
      tau_tick_ff <= 1'b0;
    end else begin
      ms_tick_ff  <= 1'b0;
      tau_tick_ff <= 1'b0;
      if (ms_cnt_ff == MS_TICK_CYC[16:0] - 17'h0_0001) begin
        ms_cnt_ff  <= 17'h0_0000;
        ms_tick_ff <= 1'b1;
      end else begin
        ms_cnt_ff <= ms_cnt_ff + 17'h0_0001;
      end
      if ({22'h00_0000, tau_cnt_ff} == `TAU_TICK_CYC - 32'h0000_0001) begin
        tau_cnt_ff  <= 10'h000;
        tau_tick_ff <= 1'b1;
      end else begin
        tau_cnt_ff <= tau_cnt_ff + 10'h001;
      end
    end
  end

  // Analog channels
  wire signed [15:0] filt_a;
  wire signed [15:0] filt_b;
  wire signed [15:0] mon_a;
  wire signed [15:0] mon_b;
  wire signed [15:0] drift_a;
  wire signed [15:0] drift_b;

  analog_channel u_chan_a (
    .sys_clk_i       (sys_clk_i),
    .reset_i         (reset_i),
    .ms_tick_i       (ms_tick_ff),
    .raw_mv_i        (analog_in_a_i),
    .calibrate_i     (calibrate_a_i),
    .offset_mv_i     (offset_a_mv_i),
    .dead_zone_mv_i  (dead_zone_a_mv_i),
    .filter_tau_ms_i (filter_tau_a_ms_i),
    .filtered_mv_o   (filt_a),
    .monitor_mv_o    (mon_a),
    .zero_drift_o    (drift_a)
  );

  analog_channel u_chan_b (
    .sys_clk_i       (sys_clk_i),
    .reset_i         (reset_i),
    .ms_tick_i       (ms_tick_ff),
    .raw_mv_i        (analog_in_b_i),
    .calibrate_i     (calibrate_b_i),
    .offset_mv_i     (offset_b_mv_i),
    .dead_zone_mv_i  (dead_zone_b_mv_i),
    .filter_tau_ms_i (filter_tau_b_ms_i),
    .filtered_mv_o   (filt_b),
    .monitor_mv_o    (mon_b),
    .zero_drift_o    (drift_b)
  );

  // Selectors follow their inputs only while stopped
  reg         torque_src_ff;
  reg         limit_src_ff;

  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      torque_src_ff <= `SRC_INTERNAL;
      limit_src_ff  <= `SRC_INTERNAL;
    end else if (motor_stopped_i) begin
      torque_src_ff <= torque_source_select_i;
      limit_src_ff  <= limit_source_select_i;
    end
  end

  // Full-scale scaling of both channels
  wire signed [31:0] fs_w;
  wire signed [31:0] prod_a;
  wire signed [31:0] prod_b;
  reg  signed [15:0] scaled_a_ff;
  reg  signed [15:0] scaled_b_ff;

  assign fs_w   = $signed({20'h0_0000, full_scale_torque_i});
  assign prod_a = filt_a * fs_w;
  assign prod_b = filt_b * fs_w;

  // Internal values clamped to 300.0%
  reg  signed [15:0] setpoint_ff;
  reg         [15:0] fwd_lim_ff;
  reg         [15:0] rev_lim_ff;

  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      scaled_a_ff <= `TORQUE_RST;
      scaled_b_ff <= `TORQUE_RST;
      setpoint_ff <= `TORQUE_RST;
      fwd_lim_ff  <= `TORQUE_LIM_RST;
      rev_lim_ff  <= `TORQUE_LIM_RST;
    end else begin
      scaled_a_ff <= sat_torque(prod_a / $signed(`FULL_SCALE_MV));
      scaled_b_ff <= sat_torque(prod_b / $signed(`FULL_SCALE_MV));
      setpoint_ff <= sat_torque({{16{internal_torque_setpoint_i[15]}},
                                 internal_torque_setpoint_i});
      fwd_lim_ff  <= sat_torque({20'h0_0000, forward_limit_value_i});
      rev_lim_ff  <= sat_torque({20'h0_0000, reverse_limit_value_i});
    end
  end

  // Reference source and torque filter
  wire signed [15:0] ref_sel;
  wire        [11:0] tau_sel;
  reg  signed [31:0] tacc_ff;
  reg  signed [31:0] nxt_tacc;
  wire signed [31:0] tdiff;
  wire signed [15:0] tfilt;

  assign ref_sel = (torque_src_ff == `SRC_ANALOG) ? scaled_a_ff : setpoint_ff;
  assign tau_sel = auto_tune_active_i ? auto_filter_tau_i : torque_filter_tau_i;
  assign tdiff   = ($signed({{16{ref_sel[15]}}, ref_sel}) <<< `FILT_FRAC) - tacc_ff;
  assign tfilt   = tacc_ff[`FILT_FRAC+15:`FILT_FRAC];

  always @* begin
    nxt_tacc = tacc_ff;
    if (tau_tick_ff) begin
      if (tau_sel == 12'h000) begin
        nxt_tacc = $signed({{16{ref_sel[15]}}, ref_sel}) <<< `FILT_FRAC;
      end else begin
        nxt_tacc = tacc_ff + tdiff / $signed({20'h0_0000, tau_sel});
      end
    end
  end

  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      tacc_ff <= 32'h0000_0000;
    end else begin
      tacc_ff <= nxt_tacc;
    end
  end

  // Active limit and clamp
  wire signed [15:0] pre_ref;
  wire signed [15:0] pos_lim;
  wire signed [15:0] neg_lim;
  wire        [15:0] b_mag;

  assign pre_ref = torque_mode_i ? tfilt : speed_reg_torque_i;
  assign b_mag   = mag16(scaled_b_ff);
  assign pos_lim = (limit_src_ff == `SRC_ANALOG) ? b_mag : fwd_lim_ff;
  assign neg_lim = (limit_src_ff == `SRC_ANALOG) ? -b_mag : -rev_lim_ff;

  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      torque_cmd_o        <= `TORQUE_RST;
      torque_limit_flag_o <= 1'b0;
    end else if (pre_ref >= pos_lim) begin
      torque_cmd_o        <= pos_lim;
      torque_limit_flag_o <= 1'b1;
    end else if (pre_ref <= neg_lim) begin
      torque_cmd_o        <= neg_lim;
      torque_limit_flag_o <= 1'b1;
    end else begin
      torque_cmd_o        <= pre_ref;
      torque_limit_flag_o <= 1'b0;
    end
  end

  // Torque reached comparison in 0.1% units
  wire [13:0] reach_lvl;
  wire [15:0] fb_mag;

  assign reach_lvl = ({5'h00, torque_reached_level_i} + {9'h000, torque_reached_hyst_i})
                     * `PCT_TO_TENTH;
  assign fb_mag    = mag16(torque_feedback_i);

  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      torque_reached_flag_o <= 1'b0;
    end else begin
      torque_reached_flag_o <= (fb_mag >= {2'b00, reach_lvl});
    end
  end

  // Output terminal mapping
  reg do0_raw;
  reg do1_raw;

  always @* begin
    case (do0_func_i)
      `FUNC_LIMIT:   do0_raw = torque_limit_flag_o;
      `FUNC_REACHED: do0_raw = torque_reached_flag_o;
      default:       do0_raw = 1'b0;
    endcase
    case (do1_func_i)
      `FUNC_LIMIT:   do1_raw = torque_limit_flag_o;
      `FUNC_REACHED: do1_raw = torque_reached_flag_o;
      default:       do1_raw = 1'b0;
    endcase
  end

  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      do0_o              <= 1'b0;
      do1_o              <= 1'b0;
      analog_a_monitor_o <= `TORQUE_RST;
      analog_b_monitor_o <= `TORQUE_RST;
      zero_drift_a_o     <= `DRIFT_RST;
      zero_drift_b_o     <= `DRIFT_RST;
    end else begin
      do0_o              <= do0_active_high_i ? do0_raw : ~do0_raw;
      do1_o              <= do1_active_high_i ? do1_raw : ~do1_raw;
      analog_a_monitor_o <= mon_a;
      analog_b_monitor_o <= mon_b;
      zero_drift_a_o     <= drift_a;
      zero_drift_b_o     <= drift_b;
    end
  end

endmodule
`default_nettype wire

/* File: sim/host_model.sv */
// Host-side model driving the two analog sample lines
`timescale 1ns/1ns
`default_nettype none
module host_model (
  // Clock
  input  wire logic               sys_clk_i,
  // Targets from the test sequence
  input  wire logic signed [15:0] a_mv_i,
  input  wire logic signed [15:0] b_mv_i,
  input  wire logic               slow_i,
  // Lines into the drive
  output var  logic signed [15:0] analog_a_o,
  output var  logic signed [15:0] analog_b_o
);
  function automatic logic signed [15:0] slew(input logic signed [15:0] cur, tgt);
    if (!slow_i || (tgt - cur < 16'sh00FA && cur - tgt < 16'sh00FA)) return tgt;
    return (tgt > cur) ? cur + 16'sh00FA : cur - 16'sh00FA;
  endfunction
  // Slow mode slews like a lagging source
  always @(negedge sys_clk_i) begin
    analog_a_o <= slew(analog_a_o, a_mv_i);
    analog_b_o <= slew(analog_b_o, b_mv_i);
  end
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// Self-checking bench for the torque reference path
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic sys_clk_i, reset_i, motor_stopped_i, torque_mode_i, calibrate_a_i, calibrate_b_i;
  logic torque_source_select_i, auto_tune_active_i, limit_source_select_i, slow;
  logic do0_active_high_i, do1_active_high_i, torque_limit_flag_o, torque_reached_flag_o;
  logic do0_o, do1_o;
  logic signed [15:0] speed_reg_torque_i, torque_feedback_i, analog_in_a_i, analog_in_b_i;
  logic signed [15:0] offset_a_mv_i, offset_b_mv_i, internal_torque_setpoint_i, a_mv, b_mv;
  logic signed [15:0] torque_cmd_o, analog_a_monitor_o, analog_b_monitor_o;
  logic signed [15:0] zero_drift_a_o, zero_drift_b_o;
  logic [9:0]  dead_zone_a_mv_i, dead_zone_b_mv_i;
  logic [15:0] filter_tau_a_ms_i, filter_tau_b_ms_i;
  logic [11:0] full_scale_torque_i, torque_filter_tau_i, auto_filter_tau_i;
  logic [11:0] forward_limit_value_i, reverse_limit_value_i;
  logic [8:0]  torque_reached_level_i;
  logic [4:0]  torque_reached_hyst_i;
  logic [7:0]  do0_func_i, do1_func_i;
  int errors, total_checks, cycles;
  logic signed [15:0] fb_tab [3] = '{16'h044C, 16'hFBB5, 16'hFBB4};
  torque_reference_path #(.MS_TICK_CYC(10)) i_torque_reference_path (.sys_clk_i, .reset_i,
    .motor_stopped_i, .torque_mode_i, .speed_reg_torque_i, .torque_feedback_i,
    .analog_in_a_i, .analog_in_b_i, .calibrate_a_i, .calibrate_b_i, .offset_a_mv_i,
    .offset_b_mv_i, .dead_zone_a_mv_i, .dead_zone_b_mv_i, .filter_tau_a_ms_i,
    .filter_tau_b_ms_i, .full_scale_torque_i, .torque_source_select_i,
    .internal_torque_setpoint_i, .torque_filter_tau_i, .auto_tune_active_i,
    .auto_filter_tau_i, .limit_source_select_i, .forward_limit_value_i,
    .reverse_limit_value_i, .torque_reached_level_i, .torque_reached_hyst_i, .do0_func_i,
    .do1_func_i, .do0_active_high_i, .do1_active_high_i, .torque_cmd_o, .torque_limit_flag_o,
    .torque_reached_flag_o, .do0_o, .do1_o, .analog_a_monitor_o, .analog_b_monitor_o,
    .zero_drift_a_o, .zero_drift_b_o);
  host_model i_host_model (.sys_clk_i, .a_mv_i(a_mv), .b_mv_i(b_mv), .slow_i(slow),
    .analog_a_o(analog_in_a_i), .analog_b_o(analog_in_b_i));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    if (errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Filter ticks every 1000 cycles, so wait past one
  task automatic ref_chk(input logic signed [15:0] c, input logic f);
    repeat (1500) @(negedge sys_clk_i);
    chk(torque_cmd_o, c);
    chk({15'h0000, torque_limit_flag_o}, {15'h0000, f});
  endtask
  task automatic pulse_cal_a;
    calibrate_a_i = 1'b1;
    @(negedge sys_clk_i);
    calibrate_a_i = 1'b0;
  endtask
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      report_and_stop();
    end
  end
  initial begin
    {reset_i, motor_stopped_i, torque_mode_i} = 3'h7;
    {calibrate_a_i, calibrate_b_i, torque_source_select_i, slow} = 4'h0;
    {auto_tune_active_i, limit_source_select_i, do1_active_high_i} = 3'h0;
    do0_active_high_i = 1'b1;
    {speed_reg_torque_i, torque_feedback_i, a_mv, b_mv} = 64'h0;
    {offset_a_mv_i, offset_b_mv_i, internal_torque_setpoint_i} = 48'h0;
    {dead_zone_a_mv_i, dead_zone_b_mv_i} = {10'h014, 10'h014};
    {filter_tau_a_ms_i, filter_tau_b_ms_i} = 32'h0;
    {full_scale_torque_i, torque_filter_tau_i, auto_filter_tau_i} = {12'h3E8, 24'h0};
    {forward_limit_value_i, reverse_limit_value_i} = {12'hBB8, 12'hBB8};
    {torque_reached_level_i, torque_reached_hyst_i} = {9'h064, 5'h0A};
    {do0_func_i, do1_func_i} = {8'h8A, 8'h8B};
    repeat (12) @(negedge sys_clk_i);
    chk(torque_cmd_o, 16'h0000);
    reset_i = 1'b0;
    internal_torque_setpoint_i = 16'h05DC;
    ref_chk(16'h05DC, 1'b0);
    internal_torque_setpoint_i = 16'hF060;
    ref_chk(16'hF448, 1'b1);
    forward_limit_value_i = 12'h3E8;
    internal_torque_setpoint_i = 16'h07D0;
    ref_chk(16'h03E8, 1'b1);
    chk({15'h0000, do0_o}, 16'h0001);
    internal_torque_setpoint_i = 16'h03E7;
    ref_chk(16'h03E7, 1'b0);
    chk({15'h0000, do0_o}, 16'h0000);
    reverse_limit_value_i = 12'h320;
    internal_torque_setpoint_i = 16'hF830;
    ref_chk(16'hFCE0, 1'b1);
    foreach (fb_tab[i]) begin
      torque_feedback_i = fb_tab[i];
      repeat (4) @(negedge sys_clk_i);
      chk({15'h0000, torque_reached_flag_o}, {15'h0000, i != 1});
      chk({15'h0000, do1_o}, {15'h0000, i == 1});
    end
    do0_func_i = 8'h80;
    do0_active_high_i = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    chk({15'h0000, do0_o}, 16'h0001);
    {forward_limit_value_i, reverse_limit_value_i} = {12'hBB8, 12'hBB8};
    internal_torque_setpoint_i = 16'h01F4;
    {motor_stopped_i, torque_source_select_i, limit_source_select_i} = 3'h3;
    a_mv = 16'h1388;
    ref_chk(16'h01F4, 1'b0);
    {motor_stopped_i, limit_source_select_i, slow} = 3'h5;
    ref_chk(16'h01F4, 1'b0);
    chk(analog_a_monitor_o, 16'h1388);
    offset_a_mv_i = 16'h03E8;
    ref_chk(16'h0190, 1'b0);
    offset_a_mv_i = 16'h0000;
    a_mv = 16'h000F;
    ref_chk(16'h0000, 1'b0);
    a_mv = 16'hFFEC;
    ref_chk(16'hFFFE, 1'b0);
    {full_scale_torque_i, a_mv} = {12'hBB8, 16'h2710};
    ref_chk(16'h0BB8, 1'b1);
    {full_scale_torque_i, a_mv} = {12'h3E8, 16'h0078};
    ref_chk(16'h000C, 1'b0);
    pulse_cal_a();
    {a_mv, offset_a_mv_i} = {16'h1400, 16'h03E8};
    ref_chk(16'h0190, 1'b0);
    chk(zero_drift_a_o, 16'h0078);
    chk(analog_a_monitor_o, 16'h1388);
    a_mv = 16'h02BC;
    repeat (20) @(negedge sys_clk_i);
    pulse_cal_a();
    repeat (20) @(negedge sys_clk_i);
    chk(zero_drift_a_o, 16'h01F4);
    {a_mv, offset_a_mv_i, filter_tau_a_ms_i} = {16'h0000, 16'h0000, 16'h0000};
    // Let the slewing source reach zero before calibrating
    repeat (5) @(negedge sys_clk_i);
    pulse_cal_a();
    {a_mv, filter_tau_a_ms_i} = {16'h1775, 16'h0005};
    repeat (1500) @(negedge sys_clk_i);
    ref_chk(16'h0258, 1'b0);
    {limit_source_select_i, b_mv, a_mv} = {1'b1, 16'h07D0, 16'hEC78};
    ref_chk(16'hFF38, 1'b1);
    chk(analog_b_monitor_o, 16'h07D0);
    {torque_mode_i, speed_reg_torque_i} = {1'b0, 16'h09C4};
    ref_chk(16'h00C8, 1'b1);
    speed_reg_torque_i = 16'hFF9C;
    ref_chk(16'hFF9C, 1'b0);
    {torque_mode_i, limit_source_select_i, torque_filter_tau_i} = {2'h2, 12'hFFF};
    // Filter settles 4 LSB short from below, hence 3005 mV
    {auto_tune_active_i, a_mv} = {1'b1, 16'h0BBD};
    ref_chk(16'h012C, 1'b0);
    calibrate_b_i = 1'b1;
    @(negedge sys_clk_i);
    calibrate_b_i = 1'b0;
    repeat (5) @(negedge sys_clk_i);
    chk(zero_drift_b_o, 16'h01F4);
    chk(analog_b_monitor_o, 16'h05DC);
    report_and_stop();
  end
endmodule
`default_nettype wire

/* File: sim/torque_path_sva.sv */
// Checker for the torque reference path outputs
`timescale 1ns/1ns
`default_nettype none
module torque_path_sva (
  // Clock and reset
  input wire               sys_clk_i,
  input wire               reset_i,
  // Watched inputs
  input wire signed [15:0] torque_feedback_i,
  input wire signed [15:0] analog_in_a_i,
  input wire signed [15:0] analog_in_b_i,
  input wire               calibrate_a_i,
  input wire               calibrate_b_i,
  input wire        [8:0]  torque_reached_level_i,
  input wire        [4:0]  torque_reached_hyst_i,
  input wire        [7:0]  do0_func_i,
  input wire        [7:0]  do1_func_i,
  input wire               do0_active_high_i,
  input wire               do1_active_high_i,
  // Watched outputs
  input wire signed [15:0] torque_cmd_o,
  input wire               torque_limit_flag_o,
  input wire               torque_reached_flag_o,
  input wire               do0_o,
  input wire               do1_o,
  input wire signed [15:0] analog_a_monitor_o,
  input wire signed [15:0] analog_b_monitor_o,
  input wire signed [15:0] zero_drift_a_o,
  input wire signed [15:0] zero_drift_b_o
);
  logic [15:0] fb_mag;
  logic [15:0] reach_lvl;
  logic        reach_now;
  assign fb_mag = torque_feedback_i[15] ? -torque_feedback_i : torque_feedback_i;
  assign reach_lvl = ({7'h00, torque_reached_level_i} + {11'h000, torque_reached_hyst_i}) * 16'h000A;
  assign reach_now = fb_mag >= reach_lvl;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  sequence cfg0(f);
    !$past(reset_i) && $stable(do0_func_i) && $stable(do0_active_high_i) && do0_func_i == f;
  endsequence
  sequence cfg1(f);
    !$past(reset_i) && $stable(do1_func_i) && $stable(do1_active_high_i) && do1_func_i == f;
  endsequence
  sequence steady_a;
    (!$past(reset_i) && !calibrate_a_i && $stable(analog_in_a_i))[*4];
  endsequence
  sequence steady_b;
    (!$past(reset_i) && !calibrate_b_i && $stable(analog_in_b_i))[*4];
  endsequence
  a_do0_limit_func: assert property (cfg0(8'h8A) |=>
    do0_o == ($past(torque_limit_flag_o) ^ !$past(do0_active_high_i))) else $error("do0 limit");
  a_do1_reached_func: assert property (cfg1(8'h8B) |=>
    do1_o == ($past(torque_reached_flag_o) ^ !$past(do1_active_high_i))) else $error("do1 reach");
  a_do0_idle_level: assert property (cfg0(8'h80) |=> do0_o == !$past(do0_active_high_i))
    else $error("do0 idle level");
  a_reached_at_level: assert property (!$past(reset_i) && $stable(torque_feedback_i)
    |=> torque_reached_flag_o == $past(reach_now)) else $error("reached flag");
  a_monitor_a_path: assert property (steady_a |->
    analog_a_monitor_o == analog_in_a_i - zero_drift_a_o) else $error("monitor a");
  a_monitor_b_path: assert property (steady_b |->
    analog_b_monitor_o == analog_in_b_i - zero_drift_b_o) else $error("monitor b");
  a_cmd_in_range: assert property (torque_cmd_o <= $signed(16'h0BB8)
    && torque_cmd_o >= $signed(16'hF448)) else $error("cmd out of range");
  a_drift_in_range: assert property ((zero_drift_a_o <= $signed(16'h01F4))
    && (zero_drift_a_o >= $signed(16'hFE0C)) && (zero_drift_b_o <= $signed(16'h01F4))
    && (zero_drift_b_o >= $signed(16'hFE0C))) else $error("drift out of range");
endmodule
bind torque_reference_path torque_path_sva i_torque_path_sva (.sys_clk_i, .reset_i,
  .torque_feedback_i, .analog_in_a_i, .analog_in_b_i, .calibrate_a_i, .calibrate_b_i,
  .torque_reached_level_i, .torque_reached_hyst_i, .do0_func_i, .do1_func_i,
  .do0_active_high_i, .do1_active_high_i, .torque_cmd_o, .torque_limit_flag_o,
  .torque_reached_flag_o, .do0_o, .do1_o, .analog_a_monitor_o, .analog_b_monitor_o,
  .zero_drift_a_o, .zero_drift_b_o);
`default_nettype wire
